// [design/isc_regs.vh]
`ifndef ISC_REGS_VH
`define ISC_REGS_VH
// Register byte offsets
`define ISC_OFF_CTRL    8'h00
`define ISC_OFF_MAIN    8'h04
`define ISC_OFF_SUB     8'h08
`define ISC_OFF_CMD     8'h0C
`define ISC_OFF_STATUS  8'h10
`define ISC_OFF_ERR     8'h14
`define ISC_OFF_IRQ_ST  8'h18
`define ISC_OFF_IRQ_MSK 8'h1C
`define ISC_OFF_RADIUS  8'h20
`define ISC_OFF_HALFD   8'h24
`define ISC_OFF_MTRAV   8'h28
`define ISC_OFF_STRAV   8'h2C
// Command codes written to CMD[2:0]
`define ISC_CMD_LIN     3'h1
`define ISC_CMD_CIRC    3'h2
`define ISC_CMD_ERST    3'h3
`define ISC_CMD_MOFF    3'h4
`define ISC_CMD_HOME    3'h5
`define ISC_CMD_FORG    3'h6
`define ISC_CMD_STOP    3'h7
// CTRL fields
`define ISC_CTRL_ABS    0
`define ISC_CTRL_RMODE  1
// Axis attribute fields (MAIN / SUB registers)
`define ISC_AX_ASSIGN   0
`define ISC_AX_INHIB    1
`define ISC_AX_SPEED    2
`define ISC_AX_MCODE    3
// Status fields
`define ISC_ST_MBUSY    0
`define ISC_ST_SBUSY    1
`define ISC_ST_MMC      2
`define ISC_ST_SMC      3
`define ISC_ST_MORG     4
`define ISC_ST_SORG     5
`define ISC_ST_ERR      6
// Interrupt bits
`define ISC_IRQ_ERR     0
`define ISC_IRQ_START   1
// Error codes
`define ISC_E_NONE      9'h000
`define ISC_E_LMBUSY    9'h0F1
`define ISC_E_LSBUSY    9'h0F2
`define ISC_E_LMINH     9'h0F4
`define ISC_E_LSINH     9'h0F5
`define ISC_E_LMMC      9'h0F7
`define ISC_E_LSMC      9'h0F8
`define ISC_E_LMORG     9'h0FA
`define ISC_E_LSORG     9'h0FB
`define ISC_E_LAXIS     9'h0FD
`define ISC_E_LZERO     9'h101
`define ISC_E_LMSPD     9'h102
`define ISC_E_LSSPD     9'h103
`define ISC_E_CRAD      9'h10E
`define ISC_E_CMBUSY    9'h10F
`define ISC_E_CSBUSY    9'h110
`define ISC_E_CMINH     9'h111
// Radius threshold factor, percent
`define ISC_RAD_PCT     8'h50
`define ISC_PCT_FULL    8'h64
`endif

// [design/isc_start_checker.v]
// Function
// RULE1: Linear start refused, code 241, while main axis moving.
// RULE2: Linear start refused, code 242, while sub axis moving.
// RULE3: Linear start refused for inhibited output: 244 main, 245 sub.
// RULE4: Linear start refused, code 247, while main aux code flag set.
// RULE5: Linear start refused, code 248, while sub aux code flag set.
// RULE6: Aux code clear command drops flags; host clears before retrying.
// RULE7: Absolute linear move needs origins: 250 main, 251 sub.
// RULE8: Origin set only by completed homing or floating-origin command.
// RULE9: Code 253 when fewer than both axes are assigned.
// RULE10: Code 257 when both travel amounts are zero.
// RULE11: Code 258/259 when main/sub axis uses speed control.
// RULE12: Code 270 when radius below 80% of half distance.
// RULE13: Circular start refused, code 271, while main axis moving.
// RULE14: Circular start refused, code 272, while sub axis moving.
// RULE15: Circular start refused, code 273, while main output inhibited.
// RULE16: Error code held until error-reset command.
// RULE17: Failed check emits no pulses and leaves axis states alone.
// RULE18: All checks evaluated together; one error code reported.
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "isc_regs.vh"
module isc_start_checker #(
  parameter HOME_CYCLES = 16,
  parameter MOVE_CYCLES = 64
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Axis activity and events
  input  wire        main_mcode_set,
  input  wire        sub_mcode_set,
  output wire        main_busy,
  output wire        sub_busy,
  output wire        pulse_main,
  output wire        pulse_sub,
  output wire        irq
);
  reg [1:0]  ctrl_reg;
  reg [3:0]  main_cfg_reg;
  reg [3:0]  sub_cfg_reg;
  reg [31:0] radius_reg;
  reg [31:0] halfd_reg;
  reg [31:0] mtrav_reg;
  reg [31:0] strav_reg;
  reg [8:0]  err_reg;
  reg [1:0]  irq_st_reg;
  reg [1:0]  irq_msk_reg;
  reg        mbusy_reg;
  reg        sbusy_reg;
  reg        mmc_reg;
  reg        smc_reg;
  reg        morg_reg;
  reg        sorg_reg;
  reg        homing_reg;
  reg [15:0] cnt_reg;
  reg        tick_reg;
  reg [31:0] rdata_reg;
  // Address phase capture
  reg        wr_pend_reg;
  reg [7:0]  addr_reg;

  wire       acc     = hsel & hready & htrans[1];
  wire       wr_now  = wr_pend_reg;
  wire       cmd_wr  = wr_now & (addr_reg == `ISC_OFF_CMD);
  wire [2:0] cmd     = hwdata[2:0];
  wire       lin_go  = cmd_wr & (cmd == `ISC_CMD_LIN);
  wire       circ_go = cmd_wr & (cmd == `ISC_CMD_CIRC);
  wire       abs_mv  = ctrl_reg[`ISC_CTRL_ABS];

  // Radius compare scaled to avoid a divider: 100*r < 80*d
  wire [39:0] rad_l = radius_reg * `ISC_PCT_FULL;
  wire [39:0] rad_r = halfd_reg * `ISC_RAD_PCT;

  reg [8:0] lin_err;
  reg [8:0] circ_err;

  // Fixed priority keeps exactly one code per refused start
  always @*
  begin
    lin_err = `ISC_E_NONE;
    if (mbusy_reg)
      lin_err = `ISC_E_LMBUSY; // RULE1 RULE18
    else if (sbusy_reg)
      lin_err = `ISC_E_LSBUSY; // RULE2
    else if (main_cfg_reg[`ISC_AX_INHIB])
      lin_err = `ISC_E_LMINH; // RULE3
    else if (sub_cfg_reg[`ISC_AX_INHIB])
      lin_err = `ISC_E_LSINH; // RULE3
    else if (mmc_reg)
      lin_err = `ISC_E_LMMC; // RULE4
    else if (smc_reg)
      lin_err = `ISC_E_LSMC; // RULE5
    else if (abs_mv & ~morg_reg)
      lin_err = `ISC_E_LMORG; // RULE7 RULE8
    else if (abs_mv & ~sorg_reg)
      lin_err = `ISC_E_LSORG; // RULE7 RULE8
    else if (~main_cfg_reg[`ISC_AX_ASSIGN] | ~sub_cfg_reg[`ISC_AX_ASSIGN])
      lin_err = `ISC_E_LAXIS; // RULE9
    else if ((mtrav_reg == 32'h0000_0000) & (strav_reg == 32'h0000_0000))
      lin_err = `ISC_E_LZERO; // RULE10
    else if (main_cfg_reg[`ISC_AX_SPEED])
      lin_err = `ISC_E_LMSPD; // RULE11
    else if (sub_cfg_reg[`ISC_AX_SPEED])
      lin_err = `ISC_E_LSSPD; // RULE11
  end

  always @*
  begin
    circ_err = `ISC_E_NONE;
    if (mbusy_reg)
      circ_err = `ISC_E_CMBUSY; // RULE13 RULE18
    else if (sbusy_reg)
      circ_err = `ISC_E_CSBUSY; // RULE14
    else if (main_cfg_reg[`ISC_AX_INHIB])
      circ_err = `ISC_E_CMINH; // RULE15
    else if (ctrl_reg[`ISC_CTRL_RMODE] & (rad_l < rad_r))
      circ_err = `ISC_E_CRAD; // RULE12
  end

  wire [8:0] new_err = lin_go ? lin_err : circ_err;
  // A held error blocks further starts until reset
  wire       held    = (err_reg != `ISC_E_NONE);
  wire       start_ok = (lin_go | circ_go) & ~held & (new_err == `ISC_E_NONE);
  wire       start_bad = (lin_go | circ_go) & ~held & (new_err != `ISC_E_NONE);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= acc & hwrite;
      if (acc)
        addr_reg <= haddr[7:0];
    end
  end

  // Register writes
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg     <= 2'h0;
      main_cfg_reg <= 4'h0;
      sub_cfg_reg  <= 4'h0;
      radius_reg   <= 32'h0000_0000;
      halfd_reg    <= 32'h0000_0000;
      mtrav_reg    <= 32'h0000_0000;
      strav_reg    <= 32'h0000_0000;
      irq_msk_reg  <= 2'h0;
    end
    else if (wr_now)
    begin
      case (addr_reg)
        `ISC_OFF_CTRL:    ctrl_reg <= hwdata[1:0];
        `ISC_OFF_MAIN:    main_cfg_reg <= hwdata[3:0];
        `ISC_OFF_SUB:     sub_cfg_reg <= hwdata[3:0];
        `ISC_OFF_RADIUS:  radius_reg <= hwdata;
        `ISC_OFF_HALFD:   halfd_reg <= hwdata;
        `ISC_OFF_MTRAV:   mtrav_reg <= hwdata;
        `ISC_OFF_STRAV:   strav_reg <= hwdata;
        `ISC_OFF_IRQ_MSK: irq_msk_reg <= hwdata[1:0];
        default:          ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Error code and aux flags
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      err_reg <= `ISC_E_NONE;
      mmc_reg <= 1'b0;
      smc_reg <= 1'b0;
    end
    else
    begin
      if (start_bad)
        err_reg <= new_err; // RULE18
      else if (cmd_wr & (cmd == `ISC_CMD_ERST))
        err_reg <= `ISC_E_NONE; // RULE16
      // A new flag event wins over a clear in the same cycle
      if (main_mcode_set)
        mmc_reg <= 1'b1;
      else if (cmd_wr & (cmd == `ISC_CMD_MOFF))
        mmc_reg <= 1'b0; // RULE6
      if (sub_mcode_set)
        smc_reg <= 1'b1;
      else if (cmd_wr & (cmd == `ISC_CMD_MOFF))
        smc_reg <= 1'b0; // RULE6
    end
  end

  // Motion engine: a fixed-length move or homing run, one pulse per tick
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mbusy_reg  <= 1'b0;
      sbusy_reg  <= 1'b0;
      homing_reg <= 1'b0;
      morg_reg   <= 1'b0;
      sorg_reg   <= 1'b0;
      cnt_reg    <= 16'h0000;
      tick_reg   <= 1'b0;
    end
    else
    begin
      tick_reg <= 1'b0;
      if (mbusy_reg)
      begin
        // Toggle so that every pulse is followed by a low gap
        tick_reg <= ~tick_reg;
        if (cnt_reg == 16'h0000)
        begin
          mbusy_reg  <= 1'b0;
          sbusy_reg  <= 1'b0;
          homing_reg <= 1'b0;
          if (homing_reg)
          begin
            morg_reg <= 1'b1; // RULE8
            sorg_reg <= 1'b1; // RULE8
          end
        end
        else
          cnt_reg <= cnt_reg - 16'h0001;
        if (cmd_wr & (cmd == `ISC_CMD_STOP))
        begin
          mbusy_reg  <= 1'b0;
          sbusy_reg  <= 1'b0;
          homing_reg <= 1'b0;
        end
      end
      else if (start_ok)
      begin
        // Refused starts never reach here, so axes stay idle
        mbusy_reg <= 1'b1; // RULE17
        sbusy_reg <= 1'b1; // RULE17
        cnt_reg   <= MOVE_CYCLES[15:0];
      end
      else if (cmd_wr & (cmd == `ISC_CMD_HOME) & ~sbusy_reg)
      begin
        mbusy_reg  <= 1'b1;
        homing_reg <= 1'b1;
        cnt_reg    <= HOME_CYCLES[15:0];
      end
      else if (cmd_wr & (cmd == `ISC_CMD_FORG) & ~sbusy_reg)
      begin
        morg_reg <= 1'b1; // RULE8
        sorg_reg <= 1'b1; // RULE8
      end
    end
  end

  // Interrupt status: write one to clear, set wins
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_st_reg <= 2'h0;
    else
    begin
      irq_st_reg[`ISC_IRQ_ERR] <= start_bad | (irq_st_reg[`ISC_IRQ_ERR] &
        ~(wr_now & (addr_reg == `ISC_OFF_IRQ_ST) & hwdata[`ISC_IRQ_ERR]));
      irq_st_reg[`ISC_IRQ_START] <= start_ok | (irq_st_reg[`ISC_IRQ_START] &
        ~(wr_now & (addr_reg == `ISC_OFF_IRQ_ST) & hwdata[`ISC_IRQ_START]));
    end
  end

  // Read data registered at address phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_reg <= 32'h0000_0000;
    else if (acc & ~hwrite)
    begin
      case (haddr[7:0])
        `ISC_OFF_CTRL:    rdata_reg <= {30'h0, ctrl_reg};
        `ISC_OFF_MAIN:    rdata_reg <= {28'h0, main_cfg_reg};
        `ISC_OFF_SUB:     rdata_reg <= {28'h0, sub_cfg_reg};
        `ISC_OFF_STATUS:  rdata_reg <= {25'h0, held, sorg_reg, morg_reg, smc_reg,
                                        mmc_reg, sbusy_reg, mbusy_reg};
        `ISC_OFF_ERR:     rdata_reg <= {23'h0, err_reg};
        `ISC_OFF_IRQ_ST:  rdata_reg <= {30'h0, irq_st_reg};
        `ISC_OFF_IRQ_MSK: rdata_reg <= {30'h0, irq_msk_reg};
        `ISC_OFF_RADIUS:  rdata_reg <= radius_reg;
        `ISC_OFF_HALFD:   rdata_reg <= halfd_reg;
        `ISC_OFF_MTRAV:   rdata_reg <= mtrav_reg;
        `ISC_OFF_STRAV:   rdata_reg <= strav_reg;
        default:          rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign hrdata     = rdata_reg;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign main_busy  = mbusy_reg;
  assign sub_busy   = sbusy_reg;
  // Homing drives only the main axis; interpolation drives both
  // Gated by busy so a stop or the last count leaves no trailing pulse
  assign pulse_main = tick_reg & mbusy_reg; // RULE17
  assign pulse_sub  = tick_reg & ~homing_reg & sbusy_reg; // RULE17
  assign irq        = |(irq_st_reg & irq_msk_reg);
endmodule
`default_nettype wire

// [tb/isc_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
`include "isc_regs.vh"
module isc_asserts #(
  parameter MOVE_CYCLES = 64
) (
  // Clock, reset and bus
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Axes
  input wire        main_busy,
  input wire        sub_busy,
  input wire        pulse_main,
  input wire        pulse_sub
);
  wire       ap;
  wire       start_wr;
  reg        dp_cmd;
  reg        rd_q;
  reg  [7:0] busy_cnt;
  assign ap = hsel && hready && htrans[1];
  assign start_wr = dp_cmd && (hwdata[2:0] == `ISC_CMD_LIN || hwdata[2:0] == `ISC_CMD_CIRC
    || hwdata[2:0] == `ISC_CMD_HOME);
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      dp_cmd   <= 1'b0;
      rd_q     <= 1'b0;
      busy_cnt <= 8'h00;
    end
    else
    begin
      dp_cmd   <= ap && hwrite && haddr[7:0] == `ISC_OFF_CMD;
      rd_q     <= ap && !hwrite;
      busy_cnt <= main_busy ? busy_cnt + 8'h01 : 8'h00;
    end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_hole;
    ap && !hwrite && haddr[7:0] >= 8'h30 ##1 1'b1;
  endsequence
  sequence s_pulse;
    pulse_main ##1 1'b1;
  endsequence
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("wait state or error");
  a_main_gate: assert property (pulse_main |-> main_busy)
    else $error("main pulse while idle");
  a_sub_gate: assert property (pulse_sub |-> sub_busy)
    else $error("sub pulse while idle");
  a_pulse_single: assert property (s_pulse |-> !pulse_main)
    else $error("main pulse too long");
  a_busy_cause: assert property ($rose(main_busy) |-> $past(start_wr))
    else $error("motion without start");
  a_busy_bound: assert property (busy_cnt <= MOVE_CYCLES + 1)
    else $error("motion too long");
  a_rdata_hold: assert property (!rd_q |-> $stable(hrdata))
    else $error("read data moved");
  a_hole_zero: assert property (s_rd_hole |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_sub_follows: assert property (pulse_sub |-> pulse_main)
    else $error("sub pulse without main");
endmodule
bind isc_start_checker isc_asserts #(.MOVE_CYCLES(MOVE_CYCLES)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .main_busy(main_busy), .sub_busy(sub_busy),
  .pulse_main(pulse_main), .pulse_sub(pulse_sub));
`default_nettype wire

// [tb/isc_host.sv]
`timescale 1ns/1ns
`default_nettype none
module isc_host (
  // Clock
  input  wire        hclk,
  // AHB-Lite master
  output logic       hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic       hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input  wire        hready,
  input  wire [31:0] hrdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Called right after a rising edge; no cycle count is assumed
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
  begin
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    q = hrdata;
  end
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "isc_regs.vh"
module testbench;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         main_mcode_set = 1'b0;
  reg         sub_mcode_set = 1'b0;
  wire        hsel, hwrite, hready, hresp, main_busy, sub_busy, pulse_main, pulse_sub, irq;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0]  htrans;
  wire [2:0]  hsize;
  reg  [31:0] q;
  reg  [31:0] tv [0:6];
  integer     failures = 0;
  integer     num_checks = 0;
  integer     cyc = 0;
  integer     i;
  integer     j;
  integer     k;
  integer     pm_cnt = 0;
  integer     ps_cnt = 0;
  always #2 hclk = ~hclk;
  // Pulses are counted mid-cycle, away from the launching edge
  always @(negedge hclk)
  begin
    if (pulse_main === 1'b1)
      pm_cnt = pm_cnt + 1;
    if (pulse_sub === 1'b1)
      ps_cnt = ps_cnt + 1;
  end
  isc_start_checker #(.HOME_CYCLES(8), .MOVE_CYCLES(20)) u_dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .main_mcode_set(main_mcode_set), .sub_mcode_set(sub_mcode_set),
    .main_busy(main_busy), .sub_busy(sub_busy), .pulse_main(pulse_main),
    .pulse_sub(pulse_sub), .irq(irq));
  isc_host u_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
  task give_verdict;
  begin
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task rd(input [7:0] a, input [31:0] e);
  begin
    u_host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  end
  endtask
  // Ports are looked at mid-cycle, away from the launching edge
  task pchk(input [3:0] e);
  begin
    @(negedge hclk);
    chk({28'h0, irq, main_busy, sub_busy, pulse_main}, {28'h0, e});
    @(posedge hclk);
  end
  endtask
  task try(input [2:0] c, input [31:0] e);
  begin
    wr(`ISC_OFF_CMD, {29'h0, c});
    rd(`ISC_OFF_ERR, e);
    wr(`ISC_OFF_CMD, {29'h0, `ISC_CMD_ERST});
  end
  endtask
  task wait_idle;
  begin
    i = 0;
    while (main_busy !== 1'b0 && i < 100)
    begin
      @(posedge hclk);
      i = i + 1;
    end
    chk({31'h0, main_busy}, 32'h0);
  end
  endtask
  task t_table;
  begin
    rd(`ISC_OFF_STATUS, 32'h0);
    rd(8'h30, 32'h0);
    wr(`ISC_OFF_IRQ_MSK, 32'h1);
    for (i = 0; i < 7; i = i + 1)
    begin
      wr(`ISC_OFF_CTRL, {28'h0, tv[i][31:28]});
      wr(`ISC_OFF_MAIN, {28'h0, tv[i][27:24]});
      wr(`ISC_OFF_SUB, {28'h0, tv[i][23:20]});
      wr(`ISC_OFF_MTRAV, {24'h0, tv[i][19:12]});
      wr(`ISC_OFF_STRAV, {24'h0, tv[i][19:12]});
      wr(`ISC_OFF_CMD, {29'h0, `ISC_CMD_LIN});
      rd(`ISC_OFF_ERR, {20'h0, tv[i][11:0]});
      pchk(4'h8);
      wr(`ISC_OFF_IRQ_ST, 32'h3);
      try(`ISC_CMD_ERST, 32'h0);
      pchk(4'h0);
    end
  end
  endtask
  task t_held;
  begin
    wr(`ISC_OFF_CTRL, 32'h0);
    wr(`ISC_OFF_MTRAV, 32'h0);
    wr(`ISC_OFF_STRAV, 32'h0);
    wr(`ISC_OFF_CMD, {29'h0, `ISC_CMD_LIN});
    wr(`ISC_OFF_MTRAV, 32'h5);
    wr(`ISC_OFF_CMD, {29'h0, `ISC_CMD_LIN});
    rd(`ISC_OFF_STATUS, 32'h40);
    try(`ISC_CMD_LIN, 32'h101);
    chk(pm_cnt, 32'h0);
    chk(ps_cnt, 32'h0);
  end
  endtask
  task t_mcode;
    for (i = 0; i < 2; i = i + 1)
    begin
      main_mcode_set <= i == 0;
      sub_mcode_set <= i == 1;
      @(posedge hclk);
      main_mcode_set <= 1'b0;
      sub_mcode_set <= 1'b0;
      rd(`ISC_OFF_STATUS, i == 0 ? 32'h4 : 32'h8);
      try(`ISC_CMD_LIN, i == 0 ? 32'hF7 : 32'hF8);
      wr(`ISC_OFF_CMD, {29'h0, `ISC_CMD_MOFF});
      rd(`ISC_OFF_STATUS, 32'h0);
    end
  endtask
  task t_move;
  begin
    wr(`ISC_OFF_CMD, {29'h0, `ISC_CMD_FORG});
    rd(`ISC_OFF_STATUS, 32'h30);
    wr(`ISC_OFF_CTRL, 32'h1);
    wr(`ISC_OFF_CMD, {29'h0, `ISC_CMD_LIN});
    rd(`ISC_OFF_STATUS, 32'h33);
    try(`ISC_CMD_LIN, 32'hF1);
    try(`ISC_CMD_CIRC, 32'h10F);
    wait_idle;
    rd(`ISC_OFF_STATUS, 32'h30);
    chk({31'h0, pm_cnt == 0}, 32'h0);
    chk(ps_cnt, pm_cnt);
  end
  endtask
  task t_circ;
  begin
    wr(`ISC_OFF_CTRL, 32'h2);
    wr(`ISC_OFF_RADIUS, 32'h3);
    wr(`ISC_OFF_HALFD, 32'h4);
    try(`ISC_CMD_CIRC, 32'h10E);
    wr(`ISC_OFF_MAIN, 32'h3);
    try(`ISC_CMD_CIRC, 32'h111);
    wr(`ISC_OFF_MAIN, 32'h1);
    wr(`ISC_OFF_RADIUS, 32'h4);
    wr(`ISC_OFF_HALFD, 32'h5);
    wr(`ISC_OFF_CMD, {29'h0, `ISC_CMD_CIRC});
    rd(`ISC_OFF_STATUS, 32'h33);
  end
  endtask
  // Reset cuts the running move; homing then restores origins
  task t_home;
  begin
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`ISC_OFF_STATUS, 32'h0);
    j = pm_cnt;
    k = ps_cnt;
    wr(`ISC_OFF_CMD, {29'h0, `ISC_CMD_HOME});
    rd(`ISC_OFF_STATUS, 32'h1);
    wait_idle;
    rd(`ISC_OFF_STATUS, 32'h30);
    chk(ps_cnt, k);
    chk({31'h0, pm_cnt == j}, 32'h0);
    wr(`ISC_OFF_MAIN, 32'h1);
    wr(`ISC_OFF_SUB, 32'h1);
    wr(`ISC_OFF_MTRAV, 32'h5);
    wr(`ISC_OFF_CMD, {29'h0, `ISC_CMD_LIN});
    wr(`ISC_OFF_CMD, {29'h0, `ISC_CMD_STOP});
    rd(`ISC_OFF_STATUS, 32'h30);
    try(`ISC_CMD_LIN, 32'h0);
  end
  endtask
  initial
  begin
    tv = '{32'h010050FD, 32'h030050F4, 32'h013050F5, 32'h05105102,
      32'h01505103, 32'h01100101, 32'h111050FA};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_table;
    t_held;
    t_mcode;
    t_move;
    t_circ;
    t_home;
    give_verdict;
  end
  always @(posedge hclk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      failures = failures + 1;
      give_verdict;
    end
  end
endmodule
`default_nettype wire
